// ==== src/vlp_device.sv ====
// device end of the local bus slave port: latches, decode, claim, ready, data
// assumes bus pins are synchronous to ref_clk; user side is a simple register port
//
// Contract
// - latch address on strobe rise, transparent when low
// - access enabled only with qualifier low, latched
// - sample direction on first delayed strobe edge
// - byte enables transparent, held from strobe rise
// - claim active on valid decode, qualifier low
// - host delays address strobe one clock
// - all bus timing on rising clock edges
// - non-data registers only byte or word; the port also accepts dword accesses at every decoded address
// - slave ready timed for bus ready
// - ready return taken directly from bus
// - board inverts bus reset into reset
`timescale 1ns/1ps
`default_nettype none
module vlp_device (
  input wire logic ref_clk,
  input wire logic reset,
  vlp_if.device bus,
  input wire logic [vlp_pkg::VLP_DEC_W-1:0] base_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [vlp_pkg::VLP_ADDR_W-1:0] reg_addr,
  output logic [vlp_pkg::VLP_BE_W-1:0] reg_be_n,
  output vlp_pkg::vlp_size_e reg_size,
  output logic [vlp_pkg::VLP_DATA_W-1:0] reg_wdata,
  input wire logic [vlp_pkg::VLP_DATA_W-1:0] reg_rdata,
  output logic busy
);
  import vlp_pkg::*;

  typedef enum logic [3:0] {
    VLP_IDLE = 4'h1,
    VLP_ADDR = 4'h2,
    VLP_READY = 4'h4,
    VLP_WAIT_RTN = 4'h8
  } vlp_state_e;

  typedef struct packed {
    vlp_state_e st;
    logic [VLP_ADDR_W-1:0] addr;
    logic [VLP_BE_W-1:0] be_n;
    logic qual;
    logic wnr;
    logic [VLP_DATA_W-1:0] rdata;
    logic [VLP_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic data_oe;
    logic claim_n;
    vlp_size_e size;
    logic late;
  } vlp_dev_s;

  vlp_dev_s r;
  vlp_dev_s next_r;

  logic [VLP_ADDR_W-1:0] addr_now;
  logic [VLP_BE_W-1:0] be_now;
  logic qual_now;
  logic hit;
  logic accept;

  localparam int VLP_LANE_W = VLP_DATA_W / VLP_BE_W;

  ////////////////////////////////////////////////////////////////////////
  // byte lanes picked by the enables; unused lanes read as zero and are ignored on writes
  function automatic logic [VLP_DATA_W-1:0] lane_mask(input logic [VLP_BE_W-1:0] be_n);
    logic [VLP_DATA_W-1:0] m;
    m = VLP_DATA_ZERO;
    for (int i = 0; i < VLP_BE_W; i++) begin
      m[i*VLP_LANE_W +: VLP_LANE_W] = {VLP_LANE_W{!be_n[i]}};
    end
    return m;
  endfunction

  // dword address against the base, enabled only with the qualifier low
  function automatic logic dec_hit(input logic [VLP_ADDR_W-1:0] a, input logic [VLP_DEC_W-1:0] base,
      input logic qual);
    return (a[VLP_ADDR_W-1:VLP_DEC_LSB] == base) && !qual;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // transparent latches: follow pins while strobe low, hold after rise
  always_comb begin
    addr_now = bus.ads_n ? r.addr : bus.addr;
    be_now = bus.ads_n ? r.be_n : bus.be_n;
    qual_now = bus.ads_n ? r.qual : bus.io_space_qualifier;
    hit = dec_hit(addr_now, base_addr, qual_now);
    accept = hit && (vlp_decode_size(be_now) != VLP_SIZE_NONE);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: strobe, sample, ready, return
  always_comb begin
    next_r = r;
    next_r.wr = 1'b0;
    next_r.rd = 1'b0;
    next_r.addr = addr_now;
    next_r.be_n = be_now;
    next_r.qual = qual_now;
    next_r.claim_n = !hit;
    case (r.st)
      VLP_IDLE: begin
        next_r.data_oe = 1'b0;
        if (!bus.ads_n) begin
          next_r.st = VLP_ADDR;
        end
      end
      VLP_ADDR: begin
        if (!bus.delayed_access_strobe_n) begin
          next_r.wnr = bus.write_not_read;
          next_r.late = 1'b0;
          if (accept) begin
            next_r.st = VLP_READY;
            next_r.wr = bus.write_not_read;
            next_r.rd = !bus.write_not_read;
            next_r.size = vlp_decode_size(be_now);
            next_r.wdata = bus.host_data & lane_mask(be_now);
          end else begin
            next_r.st = VLP_IDLE;
          end
        end else if (r.late) begin
          // delayed strobe missed a second clock: drop the access
          next_r.late = 1'b0;
          next_r.st = VLP_IDLE;
        end else begin
          next_r.late = 1'b1;
        end
      end
      VLP_READY: begin
        if (r.rd) begin
          next_r.rdata = reg_rdata & lane_mask(r.be_n);
          next_r.data_oe = 1'b1;
        end
        next_r.st = VLP_WAIT_RTN;
      end
      VLP_WAIT_RTN: begin
        if (!bus.rdy_rtn_n) begin
          next_r.st = VLP_IDLE;
          next_r.data_oe = 1'b0;
        end
      end
      default: next_r.st = VLP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r.st <= VLP_IDLE;
      r.addr <= '0;
      r.be_n <= VLP_BE_NONE;
      r.qual <= 1'b1;
      r.wnr <= 1'b0;
      r.rdata <= VLP_DATA_ZERO;
      r.wdata <= VLP_DATA_ZERO;
      r.wr <= 1'b0;
      r.rd <= 1'b0;
      r.data_oe <= 1'b0;
      r.claim_n <= 1'b1;
      r.size <= VLP_SIZE_NONE;
      r.late <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and user port
  assign bus.slave_ready_out_n = !(r.st == VLP_WAIT_RTN);
  assign bus.local_claim_out_n = r.claim_n;
  assign bus.dev_data = r.rdata;
  assign bus.dev_data_oe = r.data_oe;
  assign reg_wr = r.wr;
  assign reg_rd = r.rd;
  assign reg_addr = r.addr;
  assign reg_be_n = r.be_n;
  assign reg_size = r.size;
  assign reg_wdata = r.wdata;
  assign busy = (r.st != VLP_IDLE);
endmodule
`default_nettype wire

// ==== src/vlp_host.sv ====
// host end of the local bus slave port: strobe, delayed strobe, ready return
// assumes one access at a time from the user side; device is on the same clock
`timescale 1ns/1ps
`default_nettype none
module vlp_host (
  input wire logic ref_clk,
  input wire logic reset,
  vlp_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_qual,
  input wire logic [vlp_pkg::VLP_ADDR_W-1:0] req_addr,
  input wire logic [vlp_pkg::VLP_BE_W-1:0] req_be_n,
  input wire logic [vlp_pkg::VLP_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic done,
  output logic [vlp_pkg::VLP_DATA_W-1:0] rdata
);
  import vlp_pkg::*;

  typedef enum logic [3:0] {
    VLH_IDLE = 4'h1,
    VLH_ADS = 4'h2,
    VLH_CYCLE = 4'h4,
    VLH_RTN = 4'h8
  } vlh_state_e;

  typedef struct packed {
    vlh_state_e st;
    logic ads_n;
    logic cyc_n;
    logic [VLP_ADDR_W-1:0] addr;
    logic [VLP_BE_W-1:0] be_n;
    logic wnr;
    logic [VLP_DATA_W-1:0] wdata;
    logic rtn_n;
    logic done;
    logic [VLP_DATA_W-1:0] rdata;
    logic qual;
    logic waited;
  } vlh_s;

  vlh_s r;
  vlh_s next_r;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.cyc_n = r.ads_n;
    case (r.st)
      VLH_IDLE: begin
        next_r.rtn_n = 1'b1;
        next_r.waited = 1'b0;
        if (req) begin
          next_r.st = VLH_ADS;
          next_r.ads_n = 1'b0;
          next_r.qual = req_qual;
          next_r.addr = req_addr;
          next_r.be_n = req_be_n;
          next_r.wnr = req_write;
          next_r.wdata = req_wdata;
        end
      end
      VLH_ADS: begin
        next_r.ads_n = 1'b1;
        next_r.st = VLH_CYCLE;
      end
      VLH_CYCLE: begin
        if (!bus.slave_ready_out_n) begin
          if (!r.wnr) begin
            next_r.rdata = bus.dev_data;
          end
          next_r.rtn_n = 1'b0;
          next_r.st = VLH_RTN;
        end else if (r.cyc_n && (bus.local_claim_out_n || r.waited)) begin
          // unclaimed, or claimed with no ready in its slot: refused
          next_r.done = 1'b1;
          next_r.st = VLH_IDLE;
        end else if (r.cyc_n) begin
          next_r.waited = 1'b1;
        end
      end
      VLH_RTN: begin
        next_r.rtn_n = 1'b1;
        next_r.done = 1'b1;
        next_r.st = VLH_IDLE;
      end
      default: next_r.st = VLH_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r.st <= VLH_IDLE;
      r.ads_n <= 1'b1;
      r.cyc_n <= 1'b1;
      r.addr <= '0;
      r.be_n <= VLP_BE_NONE;
      r.wnr <= 1'b0;
      r.wdata <= VLP_DATA_ZERO;
      r.rtn_n <= 1'b1;
      r.done <= 1'b0;
      r.rdata <= VLP_DATA_ZERO;
      r.qual <= 1'b1;
      r.waited <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus.ads_n = r.ads_n;
  assign bus.delayed_access_strobe_n = r.cyc_n;
  assign bus.addr = r.addr;
  assign bus.be_n = r.be_n;
  assign bus.io_space_qualifier = r.qual;
  assign bus.write_not_read = r.wnr;
  assign bus.rdy_rtn_n = r.rtn_n;
  assign bus.host_data = r.wdata;
  assign bus.host_data_oe = r.wnr && (r.st != VLH_IDLE);
  assign bus.async_read_strobe_n = 1'b1;
  assign bus.async_write_strobe_n = 1'b1;
  assign bus.addr_bit1 = 1'b0;
  assign bus.local_bus_mode_select_n = 1'b0;
  assign bus.direct_data_select_oe = 1'b0;
  assign req_ready = (r.st == VLH_IDLE);
  assign done = r.done;
  assign rdata = r.rdata;
endmodule
`default_nettype wire

// ==== src/vlp_if.sv ====
// interface joining host end and device end of the local bus slave port
// assumes one clock for both parties; ready is driven by the device end alone, with no resolution
`timescale 1ns/1ps
`default_nettype none
interface vlp_if;
  import vlp_pkg::*;
  logic ads_n;
  logic delayed_access_strobe_n;
  logic [VLP_ADDR_W-1:0] addr;
  logic [VLP_BE_W-1:0] be_n;
  logic io_space_qualifier;
  logic write_not_read;
  logic rdy_rtn_n;
  logic slave_ready_out_n;
  logic local_claim_out_n;
  logic [VLP_DATA_W-1:0] host_data;
  logic host_data_oe;
  logic [VLP_DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic async_read_strobe_n;
  logic async_write_strobe_n;
  logic addr_bit1;
  logic local_bus_mode_select_n;
  logic direct_data_select_oe;
  modport host (
    output ads_n, delayed_access_strobe_n, addr, be_n, io_space_qualifier, write_not_read,
    output rdy_rtn_n, host_data, host_data_oe, async_read_strobe_n, async_write_strobe_n,
    output addr_bit1, local_bus_mode_select_n, direct_data_select_oe,
    input slave_ready_out_n, local_claim_out_n, dev_data, dev_data_oe
  );
  modport device (
    input ads_n, delayed_access_strobe_n, addr, be_n, io_space_qualifier, write_not_read,
    input rdy_rtn_n, host_data, host_data_oe, async_read_strobe_n, async_write_strobe_n,
    input addr_bit1, local_bus_mode_select_n, direct_data_select_oe,
    output slave_ready_out_n, local_claim_out_n, dev_data, dev_data_oe
  );
endinterface
`default_nettype wire

// ==== src/vlp_pkg.sv ====
// package for the local bus slave port: pin widths, decode constants, byte modes
// assumes both ends and the testbench share one clock, ref_clk
package vlp_pkg;
  localparam int VLP_ADDR_W = 14;
  localparam int VLP_BE_W = 4;
  localparam int VLP_DATA_W = 32;
  localparam int VLP_DEC_W = 12;
  localparam int VLP_DEC_LSB = 2;
  localparam logic [VLP_DEC_W-1:0] VLP_BASE_DEFAULT = 12'h030;
  localparam logic [VLP_BE_W-1:0] VLP_BE_NONE = 4'hf;
  localparam logic [VLP_BE_W-1:0] VLP_BE_DWORD = 4'h0;
  localparam logic [VLP_BE_W-1:0] VLP_BE_LOW_WORD = 4'hc;
  localparam logic [VLP_BE_W-1:0] VLP_BE_HIGH_WORD = 4'h3;
  localparam logic [VLP_BE_W-1:0] VLP_BE_BYTE0 = 4'he;
  localparam logic [VLP_BE_W-1:0] VLP_BE_BYTE1 = 4'hd;
  localparam logic [VLP_BE_W-1:0] VLP_BE_BYTE2 = 4'hb;
  localparam logic [VLP_BE_W-1:0] VLP_BE_BYTE3 = 4'h7;
  localparam logic [VLP_DATA_W-1:0] VLP_DATA_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    VLP_SIZE_NONE = 3'h0,
    VLP_SIZE_BYTE = 3'h1,
    VLP_SIZE_WORD = 3'h2,
    VLP_SIZE_DWORD = 3'h4
  } vlp_size_e;

  function automatic vlp_size_e vlp_decode_size(input logic [VLP_BE_W-1:0] be_n);
    vlp_size_e s;
    s = VLP_SIZE_NONE;
    case (be_n)
      VLP_BE_DWORD: s = VLP_SIZE_DWORD;
      VLP_BE_LOW_WORD, VLP_BE_HIGH_WORD: s = VLP_SIZE_WORD;
      VLP_BE_BYTE0, VLP_BE_BYTE1, VLP_BE_BYTE2, VLP_BE_BYTE3: s = VLP_SIZE_BYTE;
      default: s = VLP_SIZE_NONE;
    endcase
    return s;
  endfunction
endpackage

// ==== tb/test_vl_local_bus_slave_port.sv ====
// self-checking bench: host end and device end joined by the interface
// assumes ref_clk at 100 MHz and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module test_vl_local_bus_slave_port;
  import vlp_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, req = 1'b0, req_write = 1'b0, req_ready, done, reg_wr, reg_rd, busy;
  logic req_qual = 1'b0;
  logic [VLP_ADDR_W-1:0] req_addr = 14'h0000, reg_addr;
  logic [VLP_BE_W-1:0] req_be_n = VLP_BE_NONE, reg_be_n;
  logic [VLP_DATA_W-1:0] req_wdata = VLP_DATA_ZERO, rdata, reg_wdata, reg_rdata = VLP_DATA_ZERO, last_rd;
  logic [VLP_DEC_W-1:0] base_addr = VLP_BASE_DEFAULT;
  vlp_size_e reg_size;
  int failures = 0, n_tests = 0;
  logic [3:0] be_tab [7] = '{VLP_BE_DWORD, VLP_BE_LOW_WORD, VLP_BE_HIGH_WORD, VLP_BE_BYTE0, VLP_BE_BYTE1,
    VLP_BE_BYTE2, VLP_BE_BYTE3};
  vlp_size_e sz_tab [7] = '{VLP_SIZE_DWORD, VLP_SIZE_WORD, VLP_SIZE_WORD, VLP_SIZE_BYTE, VLP_SIZE_BYTE,
    VLP_SIZE_BYTE, VLP_SIZE_BYTE};
  vlp_if bus_if();
  vlp_host u_vlp_host(.ref_clk, .reset, .bus(bus_if), .req, .req_write, .req_qual, .req_addr, .req_be_n, .req_wdata,
    .req_ready, .done, .rdata);
  vlp_device u_vlp_device(.ref_clk, .reset, .bus(bus_if), .base_addr, .reg_wr, .reg_rd, .reg_addr, .reg_be_n,
    .reg_size, .reg_wdata, .reg_rdata, .busy);
  vlp_port_assertions u_vlp_port_assertions(.ref_clk, .reset, .base_addr, .ads_n(bus_if.ads_n),
    .delayed_access_strobe_n(bus_if.delayed_access_strobe_n), .addr(bus_if.addr), .be_n(bus_if.be_n),
    .io_space_qualifier(bus_if.io_space_qualifier), .rdy_rtn_n(bus_if.rdy_rtn_n),
    .slave_ready_out_n(bus_if.slave_ready_out_n), .local_claim_out_n(bus_if.local_claim_out_n),
    .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // byte lane k carries data when enable k is low
  function automatic logic [31:0] lanes(input logic [3:0] be);
    for (int i = 0; i < 4; i++) lanes[i*8 +: 8] = {8{!be[i]}};
  endfunction
  // one access from the host user side, judged at both user sides
  task automatic access(input logic wr, input logic [13:0] a, input logic [3:0] be, input logic [31:0] d,
      input logic hit, input vlp_size_e sz);
    logic pw, pr, cl, dn;
    logic [13:0] ca;
    logic [3:0] cb;
    logic [31:0] cd, rv;
    vlp_size_e cs;
    pw = 0; pr = 0; cl = 0; dn = 0;
    @(negedge ref_clk);
    check("req_ready", 1, req_ready);
    req = 1; req_write = wr; req_addr = a; req_be_n = be; req_wdata = d; reg_rdata = d;
    @(negedge ref_clk);
    req = 0;
    for (int i = 0; i < 16 && !dn; i++) begin
      @(negedge ref_clk);
      if (reg_wr || reg_rd) begin
        pw = reg_wr; pr = reg_rd; ca = reg_addr; cb = reg_be_n; cd = reg_wdata; cs = reg_size;
      end
      cl |= !bus_if.local_claim_out_n;
      dn = done;
      rv = rdata;
    end
    check("done", 1, dn);
    check("claim", a[13:2] == base_addr && !req_qual, cl);
    check("reg_wr", hit && wr, pw);
    check("reg_rd", hit && !wr, pr);
    if (hit) begin
      check("reg_addr", a, ca);
      check("reg_be_n", be, cb);
      check("reg_size", sz, cs);
      if (wr) check("reg_wdata", d & lanes(be), cd);
    end
    if (!wr) begin
      if (hit) last_rd = d & lanes(be);
      check("rdata", last_rd, rv);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_sizes(input logic wr);
    for (int i = 0; i < 7; i++)
      access(wr, {base_addr, i[1:0]}, be_tab[i], 32'h8765_4321 + i, 1, sz_tab[i]);
  endtask
  task automatic test_refused();
    access(0, {base_addr + 12'h001, 2'h0}, VLP_BE_DWORD, 32'h0bad_0001, 0, VLP_SIZE_NONE);
    access(1, {base_addr, 2'h1}, 4'h5, 32'h0bad_0002, 0, VLP_SIZE_NONE);
    access(0, {base_addr, 2'h2}, VLP_BE_NONE, 32'h0bad_0003, 0, VLP_SIZE_NONE);
    req_qual = 1'b1;
    access(1, {base_addr, 2'h0}, VLP_BE_DWORD, 32'h0bad_0004, 0, VLP_SIZE_NONE);
    req_qual = 1'b0;
  endtask
  task automatic test_base_move();
    @(negedge ref_clk);
    base_addr = 12'h155;
    access(1, {12'h155, 2'h3}, VLP_BE_BYTE3, 32'hcafe_f00d, 1, VLP_SIZE_BYTE);
    access(0, {VLP_BASE_DEFAULT, 2'h3}, VLP_BE_BYTE3, 32'h0000_0000, 0, VLP_SIZE_NONE);
    @(negedge ref_clk);
    base_addr = VLP_BASE_DEFAULT;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    test_done();
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    reset = 0;
    check("ready idle", 1, bus_if.slave_ready_out_n);
    test_sizes(1);
    test_sizes(0);
    test_refused();
    test_base_move();
    test_done();
  end
endmodule
`default_nettype wire

// ==== tb/vlp_port_assertions.sv ====
// checker for the local bus slave port, watching both ends across the interface
// assumes one clock and a synchronous active-high reset; instantiated beside the interface
`timescale 1ns/1ps
`default_nettype none
module vlp_port_assertions (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [vlp_pkg::VLP_DEC_W-1:0] base_addr,
  input wire logic ads_n,
  input wire logic delayed_access_strobe_n,
  input wire logic [vlp_pkg::VLP_ADDR_W-1:0] addr,
  input wire logic [vlp_pkg::VLP_BE_W-1:0] be_n,
  input wire logic io_space_qualifier,
  input wire logic rdy_rtn_n,
  input wire logic slave_ready_out_n,
  input wire logic local_claim_out_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  import vlp_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic hit;
  logic be_ok;
  assign hit = !ads_n && addr[VLP_ADDR_W-1:VLP_DEC_LSB] == base_addr && !io_space_qualifier;
  // remembers whether the strobed byte enables form a legal pattern
  always_ff @(posedge ref_clk) begin
    if (reset) be_ok <= 1'b0;
    else if (!ads_n) be_ok <= be_n inside {VLP_BE_DWORD, VLP_BE_LOW_WORD, VLP_BE_HIGH_WORD,
      VLP_BE_BYTE0, VLP_BE_BYTE1, VLP_BE_BYTE2, VLP_BE_BYTE3};
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_sample;
    $fell(delayed_access_strobe_n) && !local_claim_out_n && be_ok;
  endsequence
  sequence s_refused;
    $fell(delayed_access_strobe_n) && (local_claim_out_n || !be_ok);
  endsequence
  sequence s_ready_soon;
    ##[1:2] !slave_ready_out_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  dly_strobe_a: assert property (!$past(reset) |-> delayed_access_strobe_n == $past(ads_n))
    else $error("delayed strobe not one clock behind");
  claim_hit_a: assert property (hit |=> !local_claim_out_n)
    else $error("claim missing on decode hit");
  claim_miss_a: assert property (!ads_n && addr[VLP_ADDR_W-1:VLP_DEC_LSB] != base_addr |=> local_claim_out_n)
    else $error("claim on decode miss");
  claim_qual_a: assert property (!ads_n && io_space_qualifier |=> local_claim_out_n)
    else $error("claim with qualifier high");
  ready_answer_a: assert property (s_sample |-> s_ready_soon)
    else $error("ready late after sample");
  ready_refused_a: assert property (s_refused |-> slave_ready_out_n [*4])
    else $error("ready on refused access");
  ready_hold_a: assert property (!slave_ready_out_n && rdy_rtn_n |=> !slave_ready_out_n)
    else $error("ready dropped before return");
  ready_release_a: assert property (!slave_ready_out_n && !rdy_rtn_n |=> slave_ready_out_n)
    else $error("ready held after return");
  rtn_pulse_a: assert property (!rdy_rtn_n |-> !slave_ready_out_n ##1 rdy_rtn_n)
    else $error("ready return not a single pulse");
  no_clash_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
endmodule
`default_nettype wire
